// ### pkg/monmap_pkg.sv
// Register map, field layout and carriers for the monitor enable / reset map bank.
// Assumes an external serial front end that turns host frames into byte reads and writes.
package monmap_pkg;

  localparam int          NUM_CH            = 7;
  localparam logic [7:0]  OFS_MON_ENABLE    = 8'h03;
  localparam logic [7:0]  OFS_RESET_MASK    = 8'h04;
  localparam logic [7:0]  OFS_OV_STATUS     = 8'h05;
  localparam int          BIT_PWR_DOWN      = 7;
  localparam int          BIT_PARITY_MAP    = 7;
  localparam logic [7:0]  RD_UNMAPPED       = 8'h00;
  localparam logic [6:0]  CH_NONE           = 7'h00;

  // Host byte access, one cycle each
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       rd_valid;
    logic [7:0] rdata;
  } reg_rsp_t;

  // Power state of the comparator bank
  typedef enum logic [1:0] {
    CMP_ON  = 2'b01,
    CMP_OFF = 2'b10
  } cmp_state_t;

  // Module state apart from the OTP load flag
  typedef struct packed {
    logic [7:0] mon_enable;
    logic [7:0] reset_mask;
    logic       mon_par;
    logic       mask_par;
    logic [6:0] ov_status;
    logic       seq_en_last;
    cmp_state_t cmp;
    reg_rsp_t   rsp;
  } bank_state_t;

endpackage

// ### verilog/monmap_bank.sv
// Monitor enable, fault-to-reset mapping and overvoltage status register bank.
// Assumes byte-wide register strobes from the serial interface and synchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module monmap_bank (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // OTP defaults
  input  wire logic [7:0]          otp_mon_enable,
  input  wire logic [7:0]          otp_reset_mask,
  // Host register access
  input  wire monmap_pkg::reg_req_t req,
  output var monmap_pkg::reg_rsp_t rsp,
  // Comparator side
  input  wire logic [6:0]          ov_compare,
  input  wire logic [6:0]          uv_compare,
  input  wire logic                power_sequence_enable_input,
  input  wire logic                pd_record_done,
  output logic [6:0]               ovuv_cmp_enable,
  output logic                     off_cmp_enable,
  // Fault outputs
  output logic                     parity_fault,
  output logic                     fault_assert,
  output logic                     reset_out_n
);
  import monmap_pkg::*;

  bank_state_t s_q, s_d;
  logic        load_q;
  logic        par_fail;
  logic [6:0]  ch_fault;

  function automatic logic odd_par(input logic [7:0] v);
    odd_par = ^v;
  endfunction

  // Stored parity word lets a flipped cell show up as a fault
  assign par_fail = (odd_par(s_q.mon_enable) != s_q.mon_par) |
                    (odd_par(s_q.reset_mask) != s_q.mask_par);
  assign ch_fault = (s_q.ov_status | uv_compare) & s_q.mon_enable[6:0];

  always_comb begin
    s_d = s_q;
    s_d.rsp = '0;
    s_d.seq_en_last = power_sequence_enable_input;
    // Set beats the read clear so an event on the clear cycle survives
    if (req.rd_en && req.addr == OFS_OV_STATUS) begin
      s_d.ov_status = CH_NONE;
    end
    s_d.ov_status = s_d.ov_status | (ov_compare & s_q.mon_enable[6:0]);
    if (req.wr_en) begin
      if (req.addr == OFS_MON_ENABLE) begin
        s_d.mon_enable = req.wdata;
        s_d.mon_par = odd_par(req.wdata);
      end
      if (req.addr == OFS_RESET_MASK) begin
        s_d.reset_mask = req.wdata;
        s_d.mask_par = odd_par(req.wdata);
      end
    end
    if (req.rd_en) begin
      s_d.rsp.rd_valid = 1'b1;
      unique case (req.addr)
        OFS_MON_ENABLE: s_d.rsp.rdata = s_q.mon_enable;
        OFS_RESET_MASK: s_d.rsp.rdata = s_q.reset_mask;
        OFS_OV_STATUS:  s_d.rsp.rdata = {1'b0, s_q.ov_status};
        default:        s_d.rsp.rdata = RD_UNMAPPED;
      endcase
    end
    unique case (s_q.cmp)
      CMP_ON: begin
        if (s_q.mon_enable[BIT_PWR_DOWN] && !power_sequence_enable_input && pd_record_done) begin
          s_d.cmp = CMP_OFF;
        end
      end
      CMP_OFF: begin
        if (power_sequence_enable_input && !s_q.seq_en_last) begin
          s_d.cmp = CMP_ON;
        end
      end
      default: s_d.cmp = CMP_ON;
    endcase
    // OTP load on the first cycle after release, never from a port under reset
    if (load_q) begin
      s_d.mon_enable = otp_mon_enable;
      s_d.reset_mask = otp_reset_mask;
      s_d.mon_par = odd_par(otp_mon_enable);
      s_d.mask_par = odd_par(otp_reset_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '{cmp: CMP_ON, default: '0};
      load_q <= 1'b1;
    end else begin
      s_q <= s_d;
      load_q <= 1'b0;
    end
  end

  assign rsp = s_q.rsp;
  assign ovuv_cmp_enable = (s_q.cmp == CMP_ON) ? s_q.mon_enable[6:0] : CH_NONE;
  assign off_cmp_enable = (s_q.cmp == CMP_ON);
  assign parity_fault = par_fail;
  assign fault_assert = (|(ch_fault & s_q.reset_mask[6:0])) |
                        (par_fail & s_q.reset_mask[BIT_PARITY_MAP]);
  assign reset_out_n = ~fault_assert;

  a_power_down_entry: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.cmp == CMP_ON && s_q.mon_enable[7] && !power_sequence_enable_input && pd_record_done && !load_q)
      |=> !off_cmp_enable) else $error("comparators did not power down");

  sequence en_rise_s;
    !power_sequence_enable_input ##1 power_sequence_enable_input;
  endsequence
  a_wake_on_rise: assert property (@(posedge clk) disable iff (!resetn)
    (en_rise_s ##0 s_q.cmp == CMP_OFF) |=> off_cmp_enable) else $error("no wake on enable rise");

  a_off_cmp_kept: assert property (@(posedge clk) disable iff (!resetn)
    (!s_q.mon_enable[7] && off_cmp_enable && !load_q) |=> off_cmp_enable) else $error("OFF comparators dropped");

  a_channel_gate: assert property (@(posedge clk) disable iff (!resetn)
    off_cmp_enable |-> ovuv_cmp_enable == s_q.mon_enable[6:0]) else $error("channel enable mismatch");

  a_parity_map: assert property (@(posedge clk) disable iff (!resetn)
    (parity_fault && s_q.reset_mask[7]) |-> !reset_out_n) else $error("parity fault not on reset");

  a_chan_map: assert property (@(posedge clk) disable iff (!resetn)
    (!parity_fault && (s_q.reset_mask[6:0] == 7'h00)) |-> reset_out_n) else $error("unmapped fault on reset");

  a_ov_capture: assert property (@(posedge clk) disable iff (!resetn)
    (ov_compare[0] && s_q.mon_enable[0] && !load_q) |=> s_q.ov_status[0]) else $error("OV event lost");

  a_read_clear: assert property (@(posedge clk) disable iff (!resetn)
    (req.rd_en && req.addr == OFS_OV_STATUS && ov_compare == CH_NONE) |=> (s_q.ov_status == CH_NONE && rsp.rd_valid))
    else $error("OV status not cleared by read");

  a_reset_inverse: assert property (@(posedge clk) disable iff (!resetn)
    reset_out_n != fault_assert) else $error("reset pin not inverse");

  a_otp_load: assert property (@(posedge clk) disable iff (!resetn)
    load_q |=> (s_q.mon_enable == $past(otp_mon_enable) && !parity_fault)) else $error("OTP load missed");

  // Host steps; writes on the load cycle are lost to the OTP copy
  sequence rd_status_s;
    req.rd_en && req.addr == OFS_OV_STATUS;
  endsequence

  sequence wr_enable_s;
    req.wr_en && req.addr == OFS_MON_ENABLE && !load_q;
  endsequence

  sequence wr_mask_s;
    req.wr_en && req.addr == OFS_RESET_MASK && !load_q;
  endsequence

  a_otp_mask_load: assert property (@(posedge clk) disable iff (!resetn)
    load_q |=> s_q.reset_mask == $past(otp_reset_mask))
    else $error("OTP mask load missed");

  a_enable_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_enable_s |=> s_q.mon_enable == $past(req.wdata))
    else $error("enable write lost");

  a_mask_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_mask_s |=> s_q.reset_mask == $past(req.wdata))
    else $error("mask write lost");

  a_read_returns: assert property (@(posedge clk) disable iff (!resetn)
    rd_status_s |=> (rsp.rd_valid && rsp.rdata == {1'b0, $past(s_q.ov_status)}))
    else $error("OV status read wrong");

  a_unused_bit_zero: assert property (@(posedge clk) disable iff (!resetn)
    rd_status_s |=> !rsp.rdata[7])
    else $error("OV status bit 7 set");

  a_status_sticky: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.ov_status[0] && !(req.rd_en && req.addr == OFS_OV_STATUS)) |=> s_q.ov_status[0])
    else $error("OV status bit lost");

  a_disabled_no_set: assert property (@(posedge clk) disable iff (!resetn)
    (!s_q.mon_enable[0] && !s_q.ov_status[0]) |=> !s_q.ov_status[0])
    else $error("disabled channel set status");

  a_off_gates_all: assert property (@(posedge clk) disable iff (!resetn)
    !off_cmp_enable |-> ovuv_cmp_enable == CH_NONE)
    else $error("channel on while bank off");

  a_stay_off: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.cmp == CMP_OFF && !(power_sequence_enable_input && !s_q.seq_en_last)) |=> !off_cmp_enable)
    else $error("bank woke without rise");

  a_mapped_channel: assert property (@(posedge clk) disable iff (!resetn)
    ((s_q.ov_status[0] || uv_compare[0]) && s_q.mon_enable[0] && s_q.reset_mask[0]) |-> !reset_out_n)
    else $error("mapped fault missed");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!resetn)
    (req.rd_en && req.addr != OFS_MON_ENABLE && req.addr != OFS_RESET_MASK && req.addr != OFS_OV_STATUS)
      |=> (rsp.rd_valid && rsp.rdata == RD_UNMAPPED))
    else $error("unmapped read not zero");

  a_valid_only_on_read: assert property (@(posedge clk) disable iff (!resetn)
    !req.rd_en |=> !rsp.rd_valid)
    else $error("spurious read valid");

endmodule
`default_nettype wire

// ### sim/host_model.sv
// Supervisory host: byte reads and writes on the register strobes.
// Assumes requests are taken on the rising edge and read data returns one cycle later.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic                clk,
  // Register bus
  output var monmap_pkg::reg_req_t req,
  input  wire monmap_pkg::reg_rsp_t rsp
);
  import monmap_pkg::*;
  initial req = '0;
  // Released address and data show the inverse, not the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req <= '{1'b0, 1'b0, ~a, 8'hFF};
    d = rsp.rd_valid ? rsp.rdata : 8'hEE;
  endtask
endmodule
`default_nettype wire

// ### sim/monitor_enable_reset_map_status_tb.sv
// Testbench for the monitor enable / reset map bank.
// Assumes the host model drives the register strobes and fixed one-cycle latencies.
`timescale 1ns/1ps
`default_nettype none
module monitor_enable_reset_map_status_tb;
  import monmap_pkg::*;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [6:0] ov = 7'h00;
  logic [6:0] uv = 7'h00;
  logic       pin = 1'b1;
  logic       done = 1'b1;
  reg_req_t   req;
  reg_rsp_t   rsp;
  logic [6:0] cmp_en;
  logic       off_en, par, flt, rst_n;
  int         num_errors = 0;
  int         cmp_count = 0;
  always #2.5 clk = ~clk;
  host_model u_host (.clk(clk), .req(req), .rsp(rsp));
  monmap_bank u_dut (.clk(clk), .resetn(resetn), .otp_mon_enable(8'h5A), .otp_reset_mask(8'h3C),
    .req(req), .rsp(rsp), .ov_compare(ov), .uv_compare(uv), .power_sequence_enable_input(pin),
    .pd_record_done(done), .ovuv_cmp_enable(cmp_en), .off_cmp_enable(off_en),
    .parity_fault(par), .fault_assert(flt), .reset_out_n(rst_n));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic t_regs;
    rdchk(OFS_MON_ENABLE, 8'h5A);
    rdchk(OFS_RESET_MASK, 8'h3C);
    u_host.wr(OFS_MON_ENABLE, 8'h81);
    u_host.wr(OFS_RESET_MASK, 8'h81);
    u_host.wr(OFS_OV_STATUS, 8'hFF);
    rdchk(OFS_RESET_MASK, 8'h81);
    rdchk(OFS_OV_STATUS, 8'h00);
    rdchk(8'h7E, RD_UNMAPPED);
    chk({1'b0, cmp_en}, 8'h01);
    $display("end regs");
  endtask
  // Bit 1 is above threshold but not enabled, so only bit 0 may stick
  task automatic t_ov;
    ov = 7'h03;
    @(negedge clk);
    ov = 7'h00;
    chk({7'h00, rst_n}, 8'h00);
    rdchk(OFS_OV_STATUS, 8'h01);
    rdchk(OFS_OV_STATUS, 8'h00);
    chk({6'h00, flt, rst_n}, 8'h01);
    uv = 7'h01;
    @(negedge clk);
    chk({7'h00, rst_n}, 8'h00);
    u_host.wr(OFS_RESET_MASK, 8'h80);
    chk({6'h00, par, rst_n}, 8'h01);
    uv = 7'h00;
    $display("end ov map");
  endtask
  task automatic t_pwr;
    pin = 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk({7'h00, off_en}, 8'h00);
    chk({1'b0, cmp_en}, 8'h00);
    pin = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h00, off_en}, 8'h01);
    u_host.wr(OFS_MON_ENABLE, 8'h01);
    pin = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, off_en}, 8'h01);
    chk({1'b0, cmp_en}, 8'h01);
    pin = 1'b1;
    $display("end power");
  endtask
  // Mid-run reset must bring the OTP defaults back
  task automatic t_rst;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    rdchk(OFS_MON_ENABLE, 8'h5A);
    rdchk(OFS_RESET_MASK, 8'h3C);
    chk({6'h00, off_en, rst_n}, 8'h03);
    $display("end reset");
  endtask
  task automatic report_and_stop;
    $display("compares=%0d errors=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_regs();
    t_ov();
    t_pwr();
    t_rst();
    report_and_stop();
  end
endmodule
`default_nettype wire
